// ===== rtl/csc_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none

module csc_addr_gen
    import csc_pkg::*;
#(
    parameter int RPAG_W = 10,
    parameter int WPAG_W = 9
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Effective address request
    input wire logic ea_valid,
    input wire logic ea_frame_reg,
    input wire logic ea_write,
    input wire logic [EA_W-1:0] ea_addr,
    input wire logic [RPAG_W-1:0] read_page_reg,
    input wire logic [WPAG_W-1:0] write_page_reg,
    input wire logic stack_frame_active,
    // Resolved address
    output logic eff_valid,
    output logic [RPAG_W+PAGE_OFS_W-1:0] eff_addr
);

    localparam int EFF_W = RPAG_W + PAGE_OFS_W;

    if (RPAG_W <= WPAG_W || WPAG_W < 1) begin : g_bad_width
        $error("read page must be wider than write page");
    end

    // Candidate addresses: flat and paged
    wire logic [EFF_W-1:0] flat_addr = {{(EFF_W-EA_W){1'b0}}, ea_addr};
    wire logic [RPAG_W-1:0] page_sel = ea_write ?
        {{(RPAG_W-WPAG_W){1'b0}}, write_page_reg} : read_page_reg;
    wire logic [EFF_W-1:0] paged_addr = ea_addr[EA_W-1] ?
        {page_sel, ea_addr[PAGE_OFS_W-1:0]} : flat_addr;
    wire logic frame_flat = ea_frame_reg & stack_frame_active;
    wire logic [EFF_W-1:0] next_eff_addr = frame_flat ?
        flat_addr : paged_addr;

    // Address register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            eff_valid <= 1'b0;
            eff_addr <= '0;
        end else begin
            eff_valid <= ea_valid;
            eff_addr <= next_eff_addr;
        end
    end

    a_frame_flat: assert property (
        @(posedge ref_clk) disable iff (reset)
        ea_valid && ea_frame_reg && stack_frame_active
        |=> eff_addr == {{(EFF_W-EA_W){1'b0}}, $past(ea_addr)})
        else $error("frame register not flat while frame active");

    a_frame_paged: assert property (
        @(posedge ref_clk) disable iff (reset)
        ea_valid && ea_frame_reg && !stack_frame_active && ea_addr[EA_W-1]
        && !ea_write
        |=> eff_addr[EFF_W-1:PAGE_OFS_W] == $past(read_page_reg))
        else $error("frame register not paged while frame inactive");

    c_frame_flat: cover property (@(posedge ref_clk) disable iff (reset)
        ea_valid && frame_flat && ea_addr[EA_W-1]);

endmodule

`default_nettype wire

// ===== rtl/csc_core.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Priority bits in status are read-only while nesting disable is set.
// - Status write alters clamped flags directly or by clearing combined bit.
// - Frame active: frame and stack pointers span 0x0000-0xFFFF unpaged.
// - Frame inactive: frame and stack pointers use normal paging.
// - Rounding select 1 gives biased rounding, 0 convergent rounding.
// - Multiplier mode 1 gives integer multiply, 0 fractional.
// - Priority level is the MSB bit above status bits 7 to 5.
module csc_core
    import csc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int RPAG_W = 10,
    parameter int WPAG_W = 9
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Accumulator events and frame active input from the datapath
    input wire logic acc_a_ovf_evt,
    input wire logic acc_b_ovf_evt,
    input wire logic acc_a_sat_evt,
    input wire logic acc_b_sat_evt,
    input wire logic frame_active_in,
    // Frame and stack pointer addressing
    input wire logic ea_valid,
    input wire logic ea_frame_reg,
    input wire logic ea_write,
    input wire logic [EA_W-1:0] ea_addr,
    input wire logic [RPAG_W-1:0] read_page_reg,
    input wire logic [WPAG_W-1:0] write_page_reg,
    output logic eff_valid,
    output logic [RPAG_W+PAGE_OFS_W-1:0] eff_addr,
    // Core mode outputs
    output logic [3:0] cpu_priority_level,
    output logic rounding_select,
    output logic mult_integer_mode,
    output logic stack_frame_active,
    output logic nesting_disable,
    output logic accum_a_overflow_flag,
    output logic accum_b_overflow_flag,
    output logic accum_a_clamped_flag,
    output logic accum_b_clamped_flag,
    output logic either_accum_overflow_flag,
    output logic either_accum_clamped_flag,
    // Interrupt
    output logic irq
);

    if (ADDR_W < 5) begin : g_bad_addr
        $error("address too narrow for the register map");
    end

    logic [SR_ALU_W-1:0] alu_flags;
    logic [EVT_N-1:0] irq_status;
    logic [EVT_N-1:0] irq_mask;

    // APB phase decode
    wire logic setup = psel & ~penable;
    wire logic wr_en = psel & penable & pready & pwrite;
    wire logic [7:0] ofs = 8'(paddr);
    wire logic sel_sr = ofs == OFS_STATUS;
    wire logic sel_cc = ofs == OFS_CORE_CTRL;
    wire logic sel_ic = ofs == OFS_INT_CTRL1;
    wire logic sel_is = ofs == OFS_IRQ_STATUS;
    wire logic sel_im = ofs == OFS_IRQ_MASK;
    wire logic addr_hit = sel_sr | sel_cc | sel_ic | sel_is | sel_im;

    // Byte lane write strobes
    wire logic wr_sr_lo = wr_en & sel_sr & pstrb[0];
    wire logic wr_sr_hi = wr_en & sel_sr & pstrb[1];
    wire logic wr_cc_lo = wr_en & sel_cc & pstrb[0];
    wire logic wr_ic_hi = wr_en & sel_ic & pstrb[1];
    wire logic wr_is_lo = wr_en & sel_is & pstrb[0];
    wire logic wr_im_lo = wr_en & sel_im & pstrb[0];

    // Writing zero to the combined clamped bit clears both clamped flags unless a datapath clamp event sets one
    wire logic sab_keep = pwdata[SR_SAT_AB];
    wire logic next_sat_a = acc_a_sat_evt |
        (wr_sr_hi ? pwdata[SR_SAT_A] & sab_keep : accum_a_clamped_flag);
    wire logic next_sat_b = acc_b_sat_evt |
        (wr_sr_hi ? pwdata[SR_SAT_B] & sab_keep : accum_b_clamped_flag);

    // Overflow flags: datapath set wins over a software write
    wire logic next_ovf_a = acc_a_ovf_evt |
        (wr_sr_hi ? pwdata[SR_OVF_A] : accum_a_overflow_flag);
    wire logic next_ovf_b = acc_b_ovf_evt |
        (wr_sr_hi ? pwdata[SR_OVF_B] : accum_b_overflow_flag);

    // Priority field write, status bits blocked while nesting is disabled; core control MSB is not
    wire logic ipl_wr = wr_sr_lo & ~nesting_disable;
    wire logic [2:0] next_ipl = ipl_wr ?
        pwdata[SR_IPL_LO +: SR_IPL_W] : cpu_priority_level[2:0];
    wire logic next_ipl_msb = wr_cc_lo ?
        pwdata[CC_IPL_MSB] : cpu_priority_level[3];

    // Sticky events, set wins over write-one-to-clear
    wire logic [EVT_N-1:0] evt = {acc_b_sat_evt & ~accum_b_clamped_flag,
        acc_a_sat_evt & ~accum_a_clamped_flag,
        acc_b_ovf_evt & ~accum_b_overflow_flag,
        acc_a_ovf_evt & ~accum_a_overflow_flag};
    wire logic [EVT_N-1:0] evt_clr = wr_is_lo ? pwdata[EVT_N-1:0] : '0;
    wire logic [EVT_N-1:0] next_irq_status = evt | (irq_status & ~evt_clr);
    wire logic [EVT_N-1:0] next_irq_mask = wr_im_lo ?
        pwdata[EVT_N-1:0] : irq_mask;

    // Register read views
    wire logic [15:0] sr_view = {accum_a_overflow_flag, accum_b_overflow_flag,
        accum_a_clamped_flag, accum_b_clamped_flag,
        either_accum_overflow_flag, either_accum_clamped_flag, 2'h0,
        cpu_priority_level[2:0], 1'b0, alu_flags};
    wire logic [15:0] cc_view = {12'h000, cpu_priority_level[3],
        stack_frame_active, rounding_select, mult_integer_mode};
    wire logic [15:0] ic_view = {nesting_disable, 15'h0000};
    wire logic [15:0] rd_view = sel_sr ? sr_view :
        sel_cc ? cc_view :
        sel_ic ? ic_view :
        sel_is ? {12'h000, irq_status} :
        sel_im ? {12'h000, irq_mask} : RST_ZERO16;

    // APB answer: one access cycle after each setup
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RST_ZERO32;
        end else begin
            pready <= setup;
            pslverr <= setup & ~addr_hit;
            prdata <= (setup & ~pwrite) ? {16'h0000, rd_view} : RST_ZERO32;
        end
    end

    // Accumulator flags and combined flags
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            accum_a_overflow_flag <= 1'b0;
            accum_b_overflow_flag <= 1'b0;
            accum_a_clamped_flag <= 1'b0;
            accum_b_clamped_flag <= 1'b0;
            either_accum_overflow_flag <= 1'b0;
            either_accum_clamped_flag <= 1'b0;
        end else begin
            accum_a_overflow_flag <= next_ovf_a;
            accum_b_overflow_flag <= next_ovf_b;
            accum_a_clamped_flag <= next_sat_a;
            accum_b_clamped_flag <= next_sat_b;
            either_accum_overflow_flag <= next_ovf_a | next_ovf_b;
            either_accum_clamped_flag <= next_sat_a | next_sat_b;
        end
    end

    // Priority level, ALU flags and core modes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cpu_priority_level <= {1'b0, RST_IPL};
            alu_flags <= RST_ALU;
            rounding_select <= 1'b0;
            mult_integer_mode <= 1'b0;
            stack_frame_active <= 1'b0;
            nesting_disable <= 1'b0;
        end else begin
            cpu_priority_level <= {next_ipl_msb, next_ipl};
            alu_flags <= wr_sr_lo ? pwdata[SR_ALU_W-1:0] : alu_flags;
            rounding_select <= wr_cc_lo ? pwdata[CC_ROUND] :
                rounding_select;
            mult_integer_mode <= wr_cc_lo ? pwdata[CC_MULT] :
                mult_integer_mode;
            stack_frame_active <= frame_active_in;
            nesting_disable <= wr_ic_hi ? pwdata[IC1_NEST_DIS] :
                nesting_disable;
        end
    end

    // Event status, mask and interrupt line
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_status <= RST_EVT;
            irq_mask <= RST_EVT;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq <= |(next_irq_status & next_irq_mask);
        end
    end

    // Frame and stack pointer address resolution
    csc_addr_gen #(
        .RPAG_W(RPAG_W),
        .WPAG_W(WPAG_W)
    ) u_addr_gen (
        .ref_clk(ref_clk),
        .reset(reset),
        .ea_valid(ea_valid),
        .ea_frame_reg(ea_frame_reg),
        .ea_write(ea_write),
        .ea_addr(ea_addr),
        .read_page_reg(read_page_reg),
        .write_page_reg(write_page_reg),
        .stack_frame_active(stack_frame_active),
        .eff_valid(eff_valid),
        .eff_addr(eff_addr)
    );

    // Checks next to the logic they guard
    a_ipl_locked: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_sr_lo && nesting_disable
        |=> cpu_priority_level[2:0] == $past(cpu_priority_level[2:0]))
        else $error("priority bits changed while nesting disabled");

    a_ipl_written: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_sr_lo && !nesting_disable
        |=> cpu_priority_level[2:0] == $past(pwdata[7:5]))
        else $error("priority bits not written");

    a_sab_clear: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_sr_hi && !pwdata[SR_SAT_AB] && !acc_a_sat_evt && !acc_b_sat_evt
        |=> !accum_a_clamped_flag && !accum_b_clamped_flag
            && !either_accum_clamped_flag)
        else $error("clearing combined flag left a clamped flag set");

    a_round_mode: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_cc_lo |=> rounding_select == $past(pwdata[1]))
        else $error("rounding select not updated");

    a_mult_mode: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_cc_lo ##1 !wr_cc_lo[*2]
        |-> mult_integer_mode == $past(pwdata[0], 2))
        else $error("multiplier mode not held");

    a_prio_concat: assert property (
        @(posedge ref_clk) disable iff (reset)
        pready && !pwrite && sel_sr && !pslverr
        |-> prdata[7:5] == cpu_priority_level[2:0])
        else $error("status read priority bits mismatch");

    a_prio_msb: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_cc_lo |=> cpu_priority_level[3] == $past(pwdata[3]))
        else $error("priority msb not written");

    a_ovf_comb: assert property (
        @(posedge ref_clk) disable iff (reset)
        either_accum_overflow_flag
        == (accum_a_overflow_flag | accum_b_overflow_flag))
        else $error("combined overflow flag mismatch");

    a_ovf_set: assert property (
        @(posedge ref_clk) disable iff (reset)
        acc_b_ovf_evt |=> accum_b_overflow_flag && either_accum_overflow_flag)
        else $error("overflow event lost");

    a_sat_sticky: assert property (
        @(posedge ref_clk) disable iff (reset)
        accum_a_clamped_flag && !wr_sr_hi |=> either_accum_clamped_flag)
        else $error("combined clamped flag dropped");

    a_irq_level: assert property (@(posedge ref_clk) disable iff (reset)
        irq == |(irq_status & irq_mask))
        else $error("interrupt line does not match status and mask");

    a_apb_answer: assert property (@(posedge ref_clk) disable iff (reset)
        setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    a_sat_set: assert property (
        @(posedge ref_clk) disable iff (reset)
        acc_b_sat_evt |=> accum_b_clamped_flag && either_accum_clamped_flag)
        else $error("clamp event lost");

    a_ovf_clear: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_sr_hi && !pwdata[SR_OVF_A] && !pwdata[SR_OVF_B]
        && !acc_a_ovf_evt && !acc_b_ovf_evt
        |=> !either_accum_overflow_flag)
        else $error("combined overflow flag not cleared");

    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (reset)
        !pready |-> prdata == RST_ZERO32)
        else $error("read data not zero outside access");

    c_sab_clear: cover property (@(posedge ref_clk) disable iff (reset)
        accum_a_clamped_flag && wr_sr_hi && !pwdata[SR_SAT_AB]);

    c_ipl_blocked: cover property (@(posedge ref_clk) disable iff (reset)
        wr_sr_lo && nesting_disable);

    c_irq_raised: cover property (@(posedge ref_clk) disable iff (reset)
        $rose(irq));

    c_bad_addr: cover property (@(posedge ref_clk) disable iff (reset)
        pready && pslverr);

endmodule

`default_nettype wire

// ===== rtl/csc_pkg.sv
package csc_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h04;
    localparam logic [7:0] OFS_INT_CTRL1 = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // Status register field positions
    localparam int SR_OVF_A = 15;
    localparam int SR_OVF_B = 14;
    localparam int SR_SAT_A = 13;
    localparam int SR_SAT_B = 12;
    localparam int SR_OVF_AB = 11;
    localparam int SR_SAT_AB = 10;
    localparam int SR_IPL_LO = 5;
    localparam int SR_IPL_W = 3;
    localparam int SR_ALU_W = 4;

    // Core control register field positions
    localparam int CC_IPL_MSB = 3;
    localparam int CC_FRAME = 2;
    localparam int CC_ROUND = 1;
    localparam int CC_MULT = 0;

    // Interrupt control register 1 field position
    localparam int IC1_NEST_DIS = 15;

    // Event interrupt bits: overflow A, B, saturation A, B
    localparam int EVT_N = 4;

    // Reset values
    localparam logic [2:0] RST_IPL = 3'h0;
    localparam logic [3:0] RST_ALU = 4'h0;
    localparam logic [3:0] RST_EVT = 4'h0;
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
    localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;

    // Width of the accumulator-addressable data space offset
    localparam int EA_W = 16;
    localparam int PAGE_OFS_W = 15;

endpackage

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk_eq(32'(g), 32'(e))

module tb_top;
    import csc_pkg::*;

    // Clock, reset and stimulus
    logic ref_clk, reset;
    logic [7:0] paddr;
    logic psel, penable, pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [3:0] evt;
    logic frame_in, ea_valid, ea_frame_reg, ea_write;
    logic [15:0] ea_addr;
    logic [9:0] rpage;
    logic [8:0] wpage;
    // Observed outputs
    logic [31:0] prdata;
    logic pready, pslverr, eff_valid, irq;
    logic [24:0] eff_addr;
    logic [3:0] cpu_priority_level;
    logic rounding_select, mult_integer_mode, stack_frame_active;
    logic nesting_disable, ovf_a, ovf_b, clamp_a, clamp_b, ovf_ab, clamp_ab;
    int errors;
    int checks_done;

    csc_core i_dut (
        .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_a_ovf_evt(evt[0]), .acc_b_ovf_evt(evt[1]),
        .acc_a_sat_evt(evt[2]), .acc_b_sat_evt(evt[3]),
        .frame_active_in(frame_in), .ea_valid(ea_valid),
        .ea_frame_reg(ea_frame_reg), .ea_write(ea_write), .ea_addr(ea_addr),
        .read_page_reg(rpage), .write_page_reg(wpage),
        .eff_valid(eff_valid), .eff_addr(eff_addr),
        .cpu_priority_level(cpu_priority_level),
        .rounding_select(rounding_select),
        .mult_integer_mode(mult_integer_mode),
        .stack_frame_active(stack_frame_active),
        .nesting_disable(nesting_disable),
        .accum_a_overflow_flag(ovf_a), .accum_b_overflow_flag(ovf_b),
        .accum_a_clamped_flag(clamp_a), .accum_b_clamped_flag(clamp_b),
        .either_accum_overflow_flag(ovf_ab),
        .either_accum_clamped_flag(clamp_ab), .irq(irq)
    );

    // Free-running core clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Four-state comparison with counting
    task automatic chk_eq(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // One APB transfer; answer taken at the edge where pready is high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= 4'hf;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("[FAIL] %0t no bus answer", $time);
            close_out();
        end
        @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
        `CHK(e, 0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        `CHK(r, x);
        `CHK(e, 0);
    endtask

    // One-cycle datapath event pulse
    task automatic pulse(input logic [3:0] m);
        @(posedge ref_clk);
        evt <= m;
        @(posedge ref_clk);
        evt <= 4'h0;
        @(negedge ref_clk);
    endtask

    // One address request, result checked one cycle later
    task automatic ea(input logic f, input logic w, input logic [15:0] a,
                      input logic [24:0] x);
        @(posedge ref_clk);
        ea_valid <= 1'b1;
        ea_frame_reg <= f;
        ea_write <= w;
        ea_addr <= a;
        @(posedge ref_clk);
        ea_valid <= 1'b0;
        @(negedge ref_clk);
        `CHK(eff_valid, 1);
        `CHK(eff_addr, x);
    endtask

    task automatic t_reset;
        rd(OFS_STATUS, 32'h0);
        rd(OFS_CORE_CTRL, 32'h0);
        `CHK({cpu_priority_level, irq, ovf_ab, clamp_ab}, 7'h0);
    endtask

    task automatic t_flags;
        pulse(4'b0001);
        `CHK({ovf_a, ovf_b}, 2'b10);
        rd(OFS_STATUS, 32'h8800);
        `CHK(ovf_ab, 1);
        wr(OFS_STATUS, 32'h0);
        `CHK(ovf_ab, 0);
        pulse(4'b1000);
        `CHK(clamp_ab, 1);
        rd(OFS_STATUS, 32'h1400);
        wr(OFS_STATUS, 32'h1000);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_STATUS, 32'h2400);
        rd(OFS_STATUS, 32'h2400);
        `CHK({clamp_a, clamp_b, clamp_ab}, 3'b101);
        wr(OFS_STATUS, 32'h0);
    endtask

    task automatic t_irq;
        wr(OFS_IRQ_STATUS, 32'hf);
        wr(OFS_IRQ_MASK, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h0);
        pulse(4'b0010);
        rd(OFS_IRQ_STATUS, 32'h2);
        `CHK(irq, 0);
        wr(OFS_IRQ_MASK, 32'h2);
        `CHK(irq, 1);
        wr(OFS_IRQ_STATUS, 32'h2);
        `CHK(irq, 0);
        rd(OFS_IRQ_STATUS, 32'h0);
        wr(OFS_STATUS, 32'h0);
    endtask

    task automatic t_priority;
        wr(OFS_STATUS, 32'h00a0);
        wr(OFS_CORE_CTRL, 32'h0008);
        `CHK(cpu_priority_level, 4'hd);
        wr(OFS_INT_CTRL1, 32'h8000);
        `CHK(nesting_disable, 1);
        wr(OFS_STATUS, 32'h0040);
        rd(OFS_STATUS, 32'h00a0);
        `CHK(cpu_priority_level, 4'hd);
        wr(OFS_INT_CTRL1, 32'h0);
        wr(OFS_STATUS, 32'h0040);
        `CHK(cpu_priority_level, 4'ha);
    endtask

    task automatic t_modes;
        wr(OFS_CORE_CTRL, 32'h0003);
        `CHK({rounding_select, mult_integer_mode}, 2'b11);
        wr(OFS_CORE_CTRL, 32'h0006);
        rd(OFS_CORE_CTRL, 32'h0002);
        `CHK({rounding_select, mult_integer_mode}, 2'b10);
        wr(OFS_CORE_CTRL, 32'h0001);
        `CHK({rounding_select, mult_integer_mode}, 2'b01);
    endtask

    task automatic t_addr;
        @(posedge ref_clk);
        frame_in <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK(stack_frame_active, 1);
        rd(OFS_CORE_CTRL, 32'h0005);
        ea(1'b1, 1'b0, 16'h8123, 25'h0008123);
        ea(1'b1, 1'b1, 16'hffff, 25'h000ffff);
        ea(1'b0, 1'b0, 16'h8123, {10'h155, 15'h0123});
        @(posedge ref_clk);
        frame_in <= 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(stack_frame_active, 0);
        ea(1'b1, 1'b0, 16'h8123, {10'h155, 15'h0123});
        ea(1'b1, 1'b1, 16'h8123, {10'h0aa, 15'h0123});
        ea(1'b1, 1'b0, 16'h1234, 25'h0001234);
    endtask

    task automatic t_unmapped;
        logic [31:0] r;
        logic e;
        apb(8'h20, 1'b1, 32'hffff, r, e);
        `CHK(e, 1);
        apb(8'h20, 1'b0, 32'h0, r, e);
        `CHK(e, 1);
        `CHK(r, 0);
    endtask

    // Main sequence
    initial begin
        errors = 0;
        checks_done = 0;
        reset = 1'b1;
        {psel, penable, pwrite, pwdata, pstrb, paddr} = '0;
        {evt, frame_in, ea_valid, ea_frame_reg, ea_write, ea_addr} = '0;
        rpage = 10'h155;
        wpage = 9'h0aa;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_flags();
        t_irq();
        t_priority();
        t_modes();
        t_addr();
        t_unmapped();
        close_out();
    end
endmodule

`default_nettype wire
